// [verilog/irq_pulser_regs.svh]
// register offsets, field positions, reset values and timing for the interrupt pulser
`ifndef IRQ_PULSER_REGS_SVH
`define IRQ_PULSER_REGS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define REG_IRQ_MASK        8'h00
`define REG_WAKE_EN         8'h04
`define REG_IRQ_CTRL        8'h08
`define REG_IRQ_CAUSE       8'h0c
`define REG_IRQ_STATE       8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define GRP_SUPPLY          0
`define GRP_TEMP            1
`define GRP_BUS             2
`define GRP_HIGHSIDE        3
`define GRP_BRIDGE          4
`define GRP_SERIAL          5
`define CAUSE_WAKE          6
`define CTRL_CYC_EN         0
`define WAKE_CAN            0
`define WAKE_LIN            1
`define WAKE_PIN            2
`define WAKE_TIMER          3
`define WAKE_BRAKE          4

// supply bits 0..3: power-on reset, rail undervolt, rail short, rail overvolt
`define SUP_EXCL_MASK       8'h0f
// thermal bit 0: thermal_shutdown_2
`define THERM_EXCL_MASK     8'h01
// device status bit 0: serial access error, bit 1: checksum error
`define DEV_SER_ERR_MASK    8'h03
// bridge status bits 4..5: lowside_brake_overvolt
`define BRAKE_OV_MASK       8'h30

// ****************************************************************
// reset values
// ****************************************************************
`define IRQ_MASK_RST        6'h3f
`define WAKE_EN_RST         5'h1f
`define CYC_EN_RST          1'b1

// ****************************************************************
// timing
// ****************************************************************
`define IRQ_CLK_PERIOD_NS   4
`define IRQ_PULSE_TIME_US   100
`define IRQ_GAP_TIME_US     100
`define IRQ_REPEAT_TIME_MS  5
`define IRQ_STRAP_FILT_US   64

`endif

// [verilog/irq_pkg.sv]
// types shared by the interrupt pulser modules
package irq_pkg;

    // device operating mode as reported by the mode controller
    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } mode_t;

    // pin pulse sequencer states
    typedef enum logic [1:0] {
        PS_IDLE,
        PS_LOW,
        PS_GAP
    } pulse_state_t;

endpackage : irq_pkg

// [verilog/repeat_timer_if.sv]
// handshake between the pulser and its repeat interval timer
`timescale 1ns/1ps
interface repeat_timer_if;
    logic start;
    logic stop;
    logic expired;
    logic running;

    modport owner (output start, output stop, input expired, input running);
    modport timer (input start, input stop, output expired, output running);
endinterface : repeat_timer_if

// [verilog/repeat_timer.sv]
// one-shot interval timer used for re-signalling pending events
`timescale 1ns/1ps
module repeat_timer #(
    parameter int unsigned CYC = 1250000
) (
    input  wire logic      i_mclk,
    input  wire logic      i_nrst,
    repeat_timer_if.timer  tmr
);
    typedef struct packed {
        logic [20:0] cnt;
        logic        running;
        logic        expired;
    } tmr_state_t;

    localparam tmr_state_t TMR_RST = '{cnt: 21'h0, running: 1'b0, expired: 1'b0};

    tmr_state_t s;
    tmr_state_t n;

    // count down from the loaded interval, one-cycle expiry pulse
    always_comb begin
        n = s;
        n.expired = 1'b0;
        if (tmr.start) begin
            n.cnt = 21'(CYC - 1);
            n.running = 1'b1;
        end else if (tmr.stop) begin
            n.running = 1'b0;
        end else if (s.running) begin
            if (s.cnt == 21'h0) begin
                n.expired = 1'b1;
                n.running = 1'b0;
            end else begin
                n.cnt = s.cnt - 21'h1;
            end
        end
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            s <= TMR_RST;
        end else begin
            s <= n;
        end
    end

    assign tmr.expired = s.expired;
    assign tmr.running = s.running;
endmodule : repeat_timer

// [verilog/strap_filter.sv]
// filters the interrupt pin level in init mode to pick development mode
`timescale 1ns/1ps
module strap_filter #(
    parameter int unsigned FILT_CYC = 16000
) (
    input  wire logic i_mclk,
    input  wire logic i_nrst,
    input  wire logic i_init,
    input  wire logic i_pin,
    output logic      o_sel,
    output logic      o_valid
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        last;
        logic        sel;
        logic        valid;
    } strap_state_t;

    localparam strap_state_t STRAP_RST = '{cnt: 16'h0, last: 1'b1, sel: 1'b0, valid: 1'b0};

    strap_state_t s;
    strap_state_t n;

    // level must hold for the whole filter time before it is taken
    always_comb begin
        n = s;
        if (i_init) begin
            if (i_pin != s.last) begin
                n.last = i_pin;
                n.cnt = 16'h0;
            end else if (s.cnt == 16'(FILT_CYC - 1)) begin
                n.sel = i_pin;
                n.valid = 1'b1;
            end else begin
                n.cnt = s.cnt + 16'h1;
            end
        end
    end

    // state register, level caught only after reset release
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            s <= STRAP_RST;
        end else begin
            s <= n;
        end
    end

    assign o_sel = s.sel;
    assign o_valid = s.valid;

    AST_STRAP_FILTER: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $rose(s.valid) |-> $past(s.cnt) == 16'(FILT_CYC - 1) && $past(i_init))
        else $error("strap taken before filter time elapsed");
endmodule : strap_filter

// [verilog/status_event_interrupt_pulser.sv]
// status event interrupt pulser: group masking, pulse timing, repeat, strap
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "irq_pulser_regs.svh"

// How it works
// - low pulse of pulse width in Normal/Stop
// - pin stays high at least gap time
// - pulses never change the device mode
// - mask register enables each status group
// - supply group ORs bits except rail/reset
// - temperature group ORs bits except shutdown_2
// - bus, highside, bridge groups OR everything
// - serial group ORs access and checksum errors
// - wake events count only for enabled sources, but stop entry checks all wake and brake bits
// - status and wake interrupts work together
// - rail, shutdown_2, reset flags never pulse
// - no pulses in restart, fail-safe, sleep
// - mode return re-signals only serial errors
// - pending events repeat every repeat period
// - stop entry pulses if wake bits remain
// - status snapshot taken at pulse fall
// - cause bits stay until software clears
// - repeat pulses disabled by cyclic_irq_enable
// - events during pulse merge into it
// - init mode filters pin as strap
module status_event_interrupt_pulser #(
    parameter int unsigned PULSE_CYC  = (`IRQ_PULSE_TIME_US * 1000) / `IRQ_CLK_PERIOD_NS,
    parameter int unsigned GAP_CYC    = (`IRQ_GAP_TIME_US * 1000) / `IRQ_CLK_PERIOD_NS,
    parameter int unsigned REPEAT_CYC = (`IRQ_REPEAT_TIME_MS * 1000000) / `IRQ_CLK_PERIOD_NS,
    parameter int unsigned STRAP_CYC  = (`IRQ_STRAP_FILT_US * 1000) / `IRQ_CLK_PERIOD_NS
) (
    input  wire logic          i_mclk,
    input  wire logic          i_nrst,
    input  wire logic [7:0]    i_addr,
    input  wire logic [31:0]   i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic [31:0]        o_rdata,
    input  irq_pkg::mode_t     i_mode,
    input  wire logic [7:0]    i_supply_status,
    input  wire logic [7:0]    i_thermal_status,
    input  wire logic [7:0]    i_bus_status,
    input  wire logic [7:0]    i_highside_status,
    input  wire logic [7:0]    i_bridge_status,
    input  wire logic [7:0]    i_device_status,
    input  wire logic [3:0]    i_wake_status,
    input  wire logic          i_irq_n_in,
    output logic               o_irq_n_out,
    output logic               o_irq_n_oe,
    output logic               o_status_update,
    output logic               o_sdm_select,
    output logic               o_sdm_valid
);
    import irq_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        pulse_state_t st;
        logic [15:0]  cnt;
        logic         req;
        logic         irq_n;
        logic         oe;
        logic         upd;
        logic [31:0]  rdata;
        logic [5:0]   mask;
        logic [4:0]   wake_en;
        logic         cyc_en;
        logic [6:0]   cause;
        logic [5:0]   prev_grp;
        logic [4:0]   prev_wake;
        mode_t        prev_mode;
    } pulser_state_t;

    localparam pulser_state_t PULSER_RST = '{
        st:        PS_IDLE,
        cnt:       16'h0,
        req:       1'b0,
        irq_n:     1'b1,
        oe:        1'b0,
        upd:       1'b0,
        rdata:     32'h0,
        mask:      `IRQ_MASK_RST,
        wake_en:   `WAKE_EN_RST,
        cyc_en:    `CYC_EN_RST,
        cause:     7'h0,
        prev_grp:  6'h0,
        prev_wake: 5'h0,
        prev_mode: MODE_INIT
    };

    pulser_state_t s;
    pulser_state_t n;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // or of a status word with some bits left out
    function automatic logic or_except(input logic [7:0] v, input logic [7:0] excl);
        return |(v & ~excl);
    endfunction : or_except

    // modes in which the pin may pulse
    function automatic logic mode_active(input mode_t m);
        return (m == MODE_NORMAL) || (m == MODE_STOP);
    endfunction : mode_active

    logic [5:0] grp_raw;
    logic [5:0] grp_m;
    logic [4:0] wake_vec;
    logic       brake_hit;
    logic       active;
    logic       pending;
    logic       new_evt;
    logic       stop_evt;
    logic       back_evt;
    logic       cyc_evt;
    logic       trig;
    logic [6:0] clr;
    logic [6:0] set_bits;

    repeat_timer_if tmr ();

    // ****************************************************************
    // event sources
    // ****************************************************************
    // group flags, excluded rail/reset/shutdown bits never reach them
    assign grp_raw[`GRP_SUPPLY]   = or_except(i_supply_status, `SUP_EXCL_MASK);
    assign grp_raw[`GRP_TEMP]     = or_except(i_thermal_status, `THERM_EXCL_MASK);
    assign grp_raw[`GRP_BUS]      = |i_bus_status;
    assign grp_raw[`GRP_HIGHSIDE] = |i_highside_status;
    assign grp_raw[`GRP_BRIDGE]   = |i_bridge_status;
    assign grp_raw[`GRP_SERIAL]   = |(i_device_status & `DEV_SER_ERR_MASK);

    // per-group enable
    assign grp_m = grp_raw & s.mask;

    // wake flags only from sources configured for wake
    assign brake_hit = |(i_bridge_status & `BRAKE_OV_MASK);
    assign wake_vec  = {brake_hit, i_wake_status} & s.wake_en;

    assign active  = mode_active(i_mode);
    assign pending = (|grp_m) || (|wake_vec);

    // new flags of either kind start a pulse
    assign new_evt = (|(grp_m & ~s.prev_grp)) || (|(wake_vec & ~s.prev_wake));

    // stop entry with uncleared wake or brake bits
    assign stop_evt = (i_mode == MODE_STOP) && (s.prev_mode != MODE_STOP)
                      && ((|i_wake_status) || brake_hit);

    // back from a silent mode: only serial errors re-signal
    assign back_evt = active && !mode_active(s.prev_mode) && grp_m[`GRP_SERIAL];

    // repeat while something stays uncleared
    assign cyc_evt = tmr.expired && pending && s.cyc_en;

    assign trig = new_evt || stop_evt || back_evt || cyc_evt;

    // cause bits raised this cycle and cleared by software
    assign set_bits = {|(wake_vec & ~s.prev_wake), grp_m & ~s.prev_grp};
    assign clr      = (i_wr && (i_addr == `REG_IRQ_CAUSE)) ? i_wdata[6:0] : 7'h0;

    // ****************************************************************
    // repeat timer control
    // ****************************************************************
    // arm at each pulse start, drop when nothing is pending
    assign tmr.start = s.upd && pending && s.cyc_en;
    assign tmr.stop  = !pending || !s.cyc_en || !active;

    repeat_timer #(
        .CYC (REPEAT_CYC)
    ) u_repeat_timer (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .tmr    (tmr.timer)
    );

    // ****************************************************************
    // strap sampling in init mode
    // ****************************************************************
    strap_filter #(
        .FILT_CYC (STRAP_CYC)
    ) u_strap_filter (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .i_init  (i_mode == MODE_INIT),
        .i_pin   (i_irq_n_in),
        .o_sel   (o_sdm_select),
        .o_valid (o_sdm_valid)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    // pulse sequencer, register access and event bookkeeping
    always_comb begin
        n = s;
        n.upd = 1'b0;
        n.rdata = 32'h0;
        n.prev_grp = grp_m;
        n.prev_wake = wake_vec;
        n.prev_mode = i_mode;
        n.oe = (i_mode != MODE_INIT); // pin left free for the strap
        n.cause = (s.cause & ~clr) | set_bits;

        // pulse width, gap, abort on silent mode
        unique case (s.st)
            PS_IDLE: begin
                if (s.req && active) begin
                    n.st = PS_LOW;
                    n.cnt = 16'(PULSE_CYC - 1);
                    n.req = 1'b0;
                    n.irq_n = 1'b0;
                    n.upd = 1'b1;
                end
            end
            PS_LOW: begin
                if (s.cnt == 16'h0 || !active) begin
                    n.st = PS_GAP;
                    n.cnt = 16'(GAP_CYC - 1);
                    n.irq_n = 1'b1;
                end else begin
                    n.cnt = s.cnt - 16'h1;
                end
            end
            PS_GAP: begin
                if (s.cnt == 16'h0) begin
                    n.st = PS_IDLE;
                end else begin
                    n.cnt = s.cnt - 16'h1;
                end
            end
        endcase

        // events while the pin is low fold into that pulse
        if (!active) begin
            n.req = 1'b0;
        end else if (trig && s.irq_n && n.irq_n) begin
            n.req = 1'b1;
        end

        // register writes
        if (i_wr) begin
            case (i_addr)
                `REG_IRQ_MASK: n.mask = i_wdata[5:0];
                `REG_WAKE_EN:  n.wake_en = i_wdata[4:0];
                `REG_IRQ_CTRL: n.cyc_en = i_wdata[`CTRL_CYC_EN];
                default: ;
            endcase
        end

        // register reads, data stand one cycle
        if (i_rd) begin
            case (i_addr)
                `REG_IRQ_MASK:  n.rdata = {26'h0, s.mask};
                `REG_WAKE_EN:   n.rdata = {27'h0, s.wake_en};
                `REG_IRQ_CTRL:  n.rdata = {31'h0, s.cyc_en};
                `REG_IRQ_CAUSE: n.rdata = {25'h0, s.cause};
                `REG_IRQ_STATE: n.rdata = {27'h0, o_sdm_valid, o_sdm_select,
                                           s.req, pending, ~s.irq_n};
                default:        n.rdata = 32'h0;
            endcase
        end
    end

    // state register; nothing here touches the device mode
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            s <= PULSER_RST;
        end else begin
            s <= n;
        end
    end

    assign o_irq_n_out     = s.irq_n;
    assign o_irq_n_oe      = s.oe;
    assign o_status_update = s.upd;
    assign o_rdata         = s.rdata;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    logic [15:0] low_len_q;
    logic [15:0] high_len_q;

    // length of the current low and high stretches of the pin
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_len_q <= 16'h0;
            high_len_q <= 16'hffff;
        end else begin
            low_len_q <= o_irq_n_out ? 16'h0 : low_len_q + 16'h1;
            if (!o_irq_n_out) begin
                high_len_q <= 16'h0;
            end else if (high_len_q != 16'hffff) begin
                high_len_q <= high_len_q + 16'h1;
            end
        end
    end

    sequence s_pulse_start;
        $fell(o_irq_n_out) ##0 o_status_update;
    endsequence

    AST_PULSE_WIDTH: assert property (
        $rose(o_irq_n_out) && $past(active) |-> low_len_q == 16'(PULSE_CYC))
        else $error("interrupt pulse width wrong");
    AST_MIN_GAP: assert property (
        s_pulse_start |-> high_len_q >= 16'(GAP_CYC))
        else $error("interrupt gap too short");
    AST_UPDATE_AT_FALL: assert property (
        $fell(o_irq_n_out) |-> o_status_update)
        else $error("no status update at pulse fall");
    AST_UPDATE_ONLY_FALL: assert property (
        o_status_update |-> $fell(o_irq_n_out))
        else $error("status update without pulse fall");
    AST_SILENT_MODES: assert property (
        !active |=> o_irq_n_out)
        else $error("pin low in a silent mode");
    AST_MERGE: assert property (
        !o_irq_n_out |=> !s.req)
        else $error("event during pulse queued a second pulse");
    AST_CAUSE_STICKY: assert property (
        (($past(s.cause) & ~$past(clr)) & ~s.cause) == 7'h0)
        else $error("cause bit lost without a clear");
    AST_EXCLUDED: assert property (
        ((i_supply_status & ~`SUP_EXCL_MASK) == 8'h00)
        && ((i_thermal_status & ~`THERM_EXCL_MASK) == 8'h00)
        |-> !grp_raw[`GRP_SUPPLY] && !grp_raw[`GRP_TEMP])
        else $error("excluded flag reached a group");
    AST_RETURN: assert property (
        back_evt && o_irq_n_out |=> s.req || !o_irq_n_out)
        else $error("serial error not re-signalled on return");
    AST_CYC_OFF: assert property (
        !s.cyc_en |=> !tmr.running)
        else $error("repeat timer runs while disabled");
endmodule : status_event_interrupt_pulser

// [test/host_model.sv]
// host side of the interrupt line: resolves the pin and times its pulses
`timescale 1ns/1ps
module host_model (
    input  wire logic i_mclk,
    input  wire logic i_drv,
    input  wire logic i_oe,
    input  wire logic i_strap,
    output logic      o_pin,
    output int        o_pulses,
    output int        o_width,
    output int        o_gap
);
    logic prev_q   = 1'b1;
    int   cnt_q    = 0;
    int   pulses_q = 0;
    int   width_q  = 0;
    int   gap_q    = 0;

    // released pin falls back to the strap pull level
    assign o_pin = i_oe ? i_drv : i_strap;

    // one driver per result, the counters below own them
    assign o_pulses = pulses_q;
    assign o_width  = width_q;
    assign o_gap    = gap_q;

    // count falls, time the low phase and the high phase before it
    always @(posedge i_mclk) begin
        prev_q <= o_pin;
        if (prev_q && !o_pin) begin
            gap_q    <= cnt_q;
            pulses_q <= pulses_q + 1;
            cnt_q    <= 1;
        end else if (!prev_q && o_pin) begin
            width_q <= cnt_q;
            cnt_q   <= 1;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule : host_model

// [test/status_event_interrupt_pulser_tb.sv]
// self-checking bench for the status event interrupt pulser
`timescale 1ns/1ps
`include "irq_pulser_regs.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module status_event_interrupt_pulser_tb;
    import irq_pkg::*;
    localparam int PW = 20;
    localparam int GW = 10;
    logic        i_mclk  = 1'b0;
    logic        i_nrst  = 1'b0;
    logic [7:0]  i_addr  = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr    = 1'b0;
    logic        i_rd    = 1'b0;
    logic [31:0] o_rdata;
    mode_t       i_mode  = MODE_INIT;
    logic [7:0]  st [6]  = '{default: 8'h00};
    logic [7:0]  need [6] = '{8'h10, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01};
    mode_t       quiet [3] = '{MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE};
    logic [3:0]  wk      = 4'h0;
    logic        pin, oe, drv, upd, sdm_sel, sdm_ok;
    logic        rd_seen = 1'b0;
    logic        pin_prev = 1'b1;
    logic [31:0] e;
    logic [31:0] exp_q [$];
    logic [7:0]  v;
    int          pulses, width, gap, b;
    int          seed = 32'h5540;
    int          cycles = 0;
    int          mismatches = 0;
    int          comparisons = 0;

    status_event_interrupt_pulser #(.PULSE_CYC(PW), .GAP_CYC(GW), .REPEAT_CYC(200),
        .STRAP_CYC(8)) status_event_interrupt_pulser_i (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mode(i_mode),
        .i_supply_status(st[0]), .i_thermal_status(st[1]), .i_bus_status(st[2]),
        .i_highside_status(st[3]), .i_bridge_status(st[4]), .i_device_status(st[5]),
        .i_wake_status(wk), .i_irq_n_in(pin), .o_irq_n_out(drv), .o_irq_n_oe(oe),
        .o_status_update(upd), .o_sdm_select(sdm_sel), .o_sdm_valid(sdm_ok));
    host_model host_model_i (.i_mclk(i_mclk), .i_drv(drv), .i_oe(oe), .i_strap(1'b1),
        .o_pin(pin), .o_pulses(pulses), .o_width(width), .o_gap(gap));

    // clock and cycle ceiling
    initial begin
        forever #2 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    // watcher: read data against oldest note, update strobe at each fall
    always @(negedge i_mclk) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            `CHK("rdata", e, o_rdata)
        end
        if (pin_prev && !pin) begin
            `CHK("update", 1'b1, upd)
        end
        rd_seen  = i_rd;
        pin_prev = pin;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(posedge i_mclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(posedge i_mclk);
    endtask : rd

    // wait c cycles and expect n new pulses
    task automatic run(input int c, input int n);
        int b0;
        b0 = pulses;
        repeat (c) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("pulses", b0 + n, pulses)
        @(posedge i_mclk);
    endtask : run

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        repeat (10) @(posedge i_mclk);
        i_nrst <= 1'b1;
        repeat (20) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("sdm_ok", 1'b1, sdm_ok)
        `CHK("sdm_sel", 1'b1, sdm_sel)
        `CHK("oe", 1'b0, oe)
        @(posedge i_mclk);
        rd(`REG_IRQ_MASK, 32'h3f);
        rd(`REG_WAKE_EN, 32'h1f);
        rd(`REG_IRQ_CTRL, 32'h1);
        rd(8'h20, 32'h0);
        rd(`REG_IRQ_STATE, 32'h18);
        $display("strap and reset test done");
        i_mode <= MODE_NORMAL;
        wr(`REG_IRQ_CTRL, 32'h0);
        st[0] <= `SUP_EXCL_MASK;
        st[1] <= `THERM_EXCL_MASK;
        run(60, 0);
        for (int g = 0; g < 6; g++) begin
            st <= '{default: 8'h00};
            wr(`REG_IRQ_MASK, 32'h3f ^ (32'h1 << g));
            wr(`REG_IRQ_CAUSE, 32'h7f);
            v = 8'($random(seed));
            if (g == 4) begin
                v = v & ~`BRAKE_OV_MASK; // keep brake wake out of this group
            end
            st[g] <= v | need[g];
            run(40, 0);
            st[g] <= 8'h00;
            wr(`REG_IRQ_CAUSE, 32'h7f);
            wr(`REG_IRQ_MASK, 32'h3f);
            st[g] <= v | need[g];
            run(40, 1);
            `CHK("width", PW, width)
            rd(`REG_IRQ_CAUSE, 32'h1 << g);
        end
        st <= '{default: 8'h00};
        wr(`REG_IRQ_CAUSE, 32'h7f);
        rd(`REG_IRQ_CAUSE, 32'h0);
        rd(`REG_IRQ_CAUSE, 32'h0);
        $display("group test done");
        wr(`REG_WAKE_EN, 32'h0);
        v = 8'($random(seed));
        wk <= 4'h1 << v[1:0];
        run(40, 0);
        wk <= 4'h0;
        wr(`REG_IRQ_CAUSE, 32'h7f);
        wr(`REG_WAKE_EN, 32'h1f);
        wk <= 4'h1 << v[1:0];
        run(40, 1);
        rd(`REG_IRQ_CAUSE, 32'h40);
        i_mode <= MODE_STOP;
        run(40, 1);
        wk <= 4'h0;
        wr(`REG_IRQ_CAUSE, 32'h7f);
        $display("wake test done");
        // second event while low merges, third in gap waits out the gap
        i_mode <= MODE_NORMAL;
        b = pulses;
        st[2] <= 8'h01;
        repeat (4) @(posedge i_mclk);
        st[3] <= 8'h01;
        repeat (20) @(posedge i_mclk);
        st[1] <= 8'h02;
        run(40, 1);
        `CHK("merge", b + 2, pulses)
        `CHK("gap", 1'b1, gap >= GW + 1)
        st <= '{default: 8'h00};
        wr(`REG_IRQ_CAUSE, 32'h7f);
        wr(`REG_IRQ_CTRL, 32'h1);
        st[2] <= 8'h04;
        run(460, 3);
        wr(`REG_IRQ_CTRL, 32'h0);
        run(460, 0);
        rd(`REG_IRQ_STATE, 32'h1a);
        $display("merge and repeat test done");
        st <= '{default: 8'h00};
        wr(`REG_IRQ_CAUSE, 32'h7f);
        foreach (quiet[i]) begin
            i_mode <= quiet[i];
            st[3] <= 8'h80;
            run(40, 0);
            st[3] <= 8'h00;
            wr(`REG_IRQ_CAUSE, 32'h7f);
        end
        st[5] <= 8'h03;
        repeat (5) @(posedge i_mclk);
        i_mode <= MODE_NORMAL;
        run(40, 1);
        $display("mode test done");
        test_done();
    end
endmodule : status_event_interrupt_pulser_tb
